// >>> spi_tx_word_ctrl.sv
// Transmit word and control path with APB registers and a serial shifter.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spi_tx_word_ctrl
    import spi_tx_pkg::*;
#(
    parameter int DEPTH = 32
) (
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic PREADY_OUT,
    output logic [31:0] PRDATA_OUT,
    output logic PSLVERR_OUT,
    input wire logic LINK_CLK_IN,
    output logic SIMO_OUT,
    output logic [7:0] SEL_OUT,
    output logic SEL_OE_OUT,
    output logic BUSY_OUT
);
    import spi_tx_pkg::*;

    typedef struct packed {
        shift_state_e state;
        logic enable;
        logic master;
        logic hold;
        logic wait_delay_enable;
        logic [1:0] fsel;
        logic [7:0] select_pin_values;
        logic [15:0] payload;
        logic [7:0] idle_sel;
        logic [3:0][4:0] charlen;
        logic [3:0][7:0] wait_delay_count;
        logic [15:0] shreg;
        logic [4:0] bits_left;
        logic [8:0] cnt;
        logic cur_hold;
        logic cur_wait_delay_enable;
        logic [7:0] cur_select_pin_values;
        logic held;
        logic [7:0] sel;
        logic simo;
        logic link_d;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic busy;
    } core_s;
    core_s s;
    core_s next_s;

    logic link_s;
    logic access;
    logic wr;
    logic rd;
    logic hit_word;
    logic hit_ctrl;
    logic hit_fmt;
    logic mapped;
    logic data_lane;
    logic want_push;
    logic push_ready;
    logic pop_valid;
    logic pop;
    logic link_rise;
    logic [ENTRY_W-1:0] push_data;
    logic [ENTRY_W-1:0] pop_data;
    logic [$clog2(DEPTH):0] fill;
    logic [1:0] fidx;

    // Brings the external bit clock into the system clock domain.
    spi_tx_sync u_link_sync (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(LINK_CLK_IN),
        .q_out(link_s)
    );

    // Holding buffer for words waiting on the shifter.
    spi_tx_fifo #(
        .W(ENTRY_W),
        .D(DEPTH)
    ) u_hold_buf (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .clr_in(!s.enable),
        .wr_valid_in(want_push),
        .wr_ready_out(push_ready),
        .wr_data_in(push_data),
        .rd_valid_out(pop_valid),
        .rd_ready_in(pop),
        .rd_data_out(pop_data),
        .count_out(fill)
    );

    // Address decode and access qualifiers.
    assign access = PSEL_IN & PENABLE_IN & !s.pready;
    assign wr = access & PWRITE_IN;
    assign rd = access & !PWRITE_IN;
    assign hit_word = (PADDR_IN == OFS_TX_WORD);
    assign hit_ctrl = (PADDR_IN == OFS_TX_CTRL);
    assign hit_fmt = (PADDR_IN[7:4] == OFS_FMT0[7:4]) &
                     (PADDR_IN[1:0] == 2'b00);
    assign fidx = PADDR_IN[3:2];
    assign mapped = hit_word | hit_ctrl | hit_fmt |
                    (PADDR_IN == OFS_GLOBAL) |
                    (PADDR_IN == OFS_IDLE_SEL) |
                    (PADDR_IN == OFS_STATUS);
    assign data_lane = |PSTRB_IN[1:0];
    // Only a write reaching the payload lanes queues a word.
    assign want_push = wr & s.enable & data_lane & (hit_word | hit_ctrl);
    assign link_rise = link_s & !s.link_d;
    // The shifter pulls a word only while idle.
    assign pop = (s.state == ST_IDLE) & pop_valid;

    // Queued entry carries the control fields that apply to it.
    always_comb begin
        push_data = {s.hold, s.wait_delay_enable, s.fsel, s.select_pin_values, s.payload};
        if (hit_ctrl) begin
            if (PSTRB_IN[3]) begin
                push_data[27] = PWDATA_IN[HOLD_BIT];
                push_data[26] = PWDATA_IN[WAIT_DELAY_ENABLE_BIT];
                push_data[25:24] = PWDATA_IN[FSEL_LSB +: 2];
            end
            if (PSTRB_IN[2]) begin
                push_data[23:16] = PWDATA_IN[SELECT_PIN_VALUES_LSB +: 8];
            end
        end
        if (PSTRB_IN[0]) begin
            push_data[7:0] = PWDATA_IN[7:0];
        end
        if (PSTRB_IN[1]) begin
            push_data[15:8] = PWDATA_IN[15:8];
        end
    end

    // Register file, bus answer and transmit sequencer.
    always_comb begin
        next_s = s;
        next_s.link_d = link_s;
        // One wait state; a queued write stalls while the buffer is full.
        next_s.pready = access & (!want_push | push_ready);
        next_s.pslverr = access & !mapped;
        next_s.prdata = 32'h0000_0000;
        if (rd) begin
            if (hit_word) begin
                next_s.prdata = {16'h0000, s.payload};
            end else if (hit_ctrl) begin
                next_s.prdata = {3'b000, s.hold, 1'b0, s.wait_delay_enable, s.fsel,
                                 s.select_pin_values, s.payload};
            end else if (hit_fmt) begin
                next_s.prdata = {16'h0000, s.wait_delay_count[fidx], 3'b000,
                                 s.charlen[fidx]};
            end else if (PADDR_IN == OFS_GLOBAL) begin
                next_s.prdata = {30'h0, s.master, s.enable};
            end else if (PADDR_IN == OFS_IDLE_SEL) begin
                next_s.prdata = {24'h000000, s.idle_sel};
            end else if (PADDR_IN == OFS_STATUS) begin
                next_s.prdata = {16'h0000, 2'b00, 6'(fill), 4'h0,
                                 s.held, s.state, pop_valid};
            end
        end
        if (wr) begin
            if (PADDR_IN == OFS_GLOBAL && PSTRB_IN[0]) begin
                next_s.enable = PWDATA_IN[ENABLE_BIT];
                next_s.master = PWDATA_IN[MASTER_BIT];
                if (!PWDATA_IN[ENABLE_BIT]) begin
                    next_s.payload = 16'h0000;
                end
            end
            if (PADDR_IN == OFS_IDLE_SEL && PSTRB_IN[0]) begin
                next_s.idle_sel = PWDATA_IN[7:0];
            end
            if (hit_fmt && PSTRB_IN[0]) begin
                next_s.charlen[fidx] = PWDATA_IN[CHARLEN_LSB +: 5];
            end
            if (hit_fmt && PSTRB_IN[1]) begin
                next_s.wait_delay_count[fidx] = PWDATA_IN[WAIT_DELAY_COUNT_LSB +: 8];
            end
            // Control fields update even with no payload lanes.
            if (hit_ctrl && PSTRB_IN[3]) begin
                next_s.hold = PWDATA_IN[HOLD_BIT];
                next_s.wait_delay_enable = PWDATA_IN[WAIT_DELAY_ENABLE_BIT];
                next_s.fsel = PWDATA_IN[FSEL_LSB +: 2];
            end
            if (hit_ctrl && PSTRB_IN[2]) begin
                next_s.select_pin_values = PWDATA_IN[SELECT_PIN_VALUES_LSB +: 8];
                // New select values end a held select.
                if (s.held && s.state == ST_IDLE &&
                    PWDATA_IN[SELECT_PIN_VALUES_LSB +: 8] != s.cur_select_pin_values) begin
                    next_s.held = 1'b0;
                    next_s.sel = s.idle_sel;
                    next_s.state = ST_GAP;
                    next_s.cnt = 9'(MIN_GAP_CYC - 1);
                end
            end
            if (want_push && push_ready) begin
                next_s.payload = push_data[15:0];
            end
        end
        case (s.state)
            ST_IDLE: begin
                if (!s.held) begin
                    next_s.sel = s.idle_sel;
                end
                if (pop) begin
                    next_s.state = ST_SHIFT;
                    next_s.shreg = pop_data[15:0];
                    next_s.bits_left = s.charlen[pop_data[25:24]];
                    next_s.cur_select_pin_values = pop_data[23:16];
                    next_s.cur_wait_delay_enable = pop_data[26];
                    next_s.cur_hold = pop_data[27];
                    next_s.held = 1'b0;
                    if (s.master) begin
                        next_s.sel = pop_data[23:16];
                    end
                end
            end
            ST_SHIFT: begin
                // Right-justified data leaves most significant bit first.
                if (link_rise) begin
                    if (s.bits_left != 5'd0) begin
                        next_s.simo = s.shreg[4'(s.bits_left - 5'd1)];
                        next_s.bits_left = s.bits_left - 5'd1;
                    end else begin
                        next_s.state = ST_T2C;
                        next_s.cnt = 9'(T2C_CYC - 1);
                    end
                end
            end
            ST_T2C: begin
                if (s.cnt != 9'd0) begin
                    next_s.cnt = s.cnt - 9'd1;
                end else if (s.master && s.cur_hold) begin
                    next_s.held = 1'b1;
                    next_s.state = ST_IDLE;
                end else begin
                    next_s.sel = s.idle_sel;
                    next_s.state = ST_GAP;
                    next_s.cnt = 9'(MIN_GAP_CYC - 1);
                    if (s.master && s.cur_wait_delay_enable) begin
                        next_s.cnt = 9'(MIN_GAP_CYC - 1) +
                                     9'(s.wait_delay_count[s.fsel]);
                    end
                end
            end
            ST_GAP: begin
                // No new word starts until the delay counter runs out.
                if (s.cnt != 9'd0) begin
                    next_s.cnt = s.cnt - 9'd1;
                end else begin
                    next_s.state = ST_IDLE;
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
        next_s.busy = (next_s.state != ST_IDLE); // Registered busy flag.
    end

    // Registers the whole block state.
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s <= '0;
            s.idle_sel <= IDLE_SEL_RST;
            s.sel <= IDLE_SEL_RST;
            s.charlen <= {4{CHARLEN_RST}};
            s.wait_delay_count <= {4{WAIT_DELAY_COUNT_RST}};
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state register.
    assign PREADY_OUT = s.pready;
    assign PRDATA_OUT = s.prdata;
    assign PSLVERR_OUT = s.pslverr;
    assign SIMO_OUT = s.simo;
    assign SEL_OUT = s.sel;
    assign SEL_OE_OUT = s.master;
    assign BUSY_OUT = s.busy;

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    a_reserved_read: assert property (
        rd && hit_word |=> PRDATA_OUT[31:16] == 16'h0000)
        else $error("reserved transmit word bits read nonzero");
    a_disable_clear: assert property (
        wr && PADDR_IN == OFS_GLOBAL && PSTRB_IN[0] && !PWDATA_IN[0]
        |=> s.payload == 16'h0000)
        else $error("payload not cleared by disable");
    a_direct_load: assert property (
        s.state == ST_IDLE && pop_valid |=> s.state == ST_SHIFT)
        else $error("empty shifter did not take a waiting word");
    a_ctrl_only_write: assert property (
        wr && hit_ctrl && PSTRB_IN[1:0] == 2'b00 |-> !want_push)
        else $error("control-only write queued a word");
    a_select_drive: assert property (
        s.state == ST_SHIFT && s.master |-> SEL_OUT == s.cur_select_pin_values)
        else $error("select pins differ from select values");
    a_min_gap: assert property (
        s.state == ST_T2C && s.cnt == 9'd0 && !(s.master && s.cur_hold)
        |=> (s.state == ST_GAP && SEL_OUT == $past(s.idle_sel)) [*2])
        else $error("select gap shorter than two clocks");
    a_wait_load: assert property (
        s.state == ST_T2C && s.cnt == 9'd0 && s.master && s.cur_wait_delay_enable &&
        !s.cur_hold
        |=> s.cnt == 9'(MIN_GAP_CYC - 1) + 9'($past(s.wait_delay_count[s.fsel])))
        else $error("wait delay count not loaded");
    a_hold_keep: assert property (
        s.state == ST_T2C && s.cnt == 9'd0 && s.master && s.cur_hold
        |=> s.held && SEL_OUT == $past(SEL_OUT))
        else $error("held select dropped after transfer");
endmodule // spi_tx_word_ctrl
`default_nettype wire

// >>> spi_tx_pkg.sv
// Shared constants and types of the transmit word and control path.
package spi_tx_pkg;
    // Register byte offsets on the APB port.
    localparam logic [7:0] OFS_TX_WORD = 8'h00;
    localparam logic [7:0] OFS_TX_CTRL = 8'h04;
    localparam logic [7:0] OFS_GLOBAL = 8'h08;
    localparam logic [7:0] OFS_IDLE_SEL = 8'h0C;
    localparam logic [7:0] OFS_FMT0 = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Field positions inside the control word and other registers.
    localparam int HOLD_BIT = 28;
    localparam int WAIT_DELAY_ENABLE_BIT = 26;
    localparam int FSEL_LSB = 24;
    localparam int SELECT_PIN_VALUES_LSB = 16;
    localparam int ENABLE_BIT = 0;
    localparam int MASTER_BIT = 1;
    localparam int CHARLEN_LSB = 0;
    localparam int WAIT_DELAY_COUNT_LSB = 8;
    // Reset values.
    localparam logic [7:0] IDLE_SEL_RST = 8'hFF;
    localparam logic [4:0] CHARLEN_RST = 5'h10;
    localparam logic [7:0] WAIT_DELAY_COUNT_RST = 8'h00;
    // Timing: transmit-to-select delay and the least select gap.
    localparam int CLK_NS = 8;
    localparam int T2C_NS = 40;
    localparam int T2C_CYC = (T2C_NS + CLK_NS - 1) / CLK_NS;
    localparam int MIN_GAP_CYC = 2;
    // Queued entry: hold, wait enable, format, select values, payload.
    localparam int ENTRY_W = 28;
    // Shifter states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_T2C = 2'b11,
        ST_GAP = 2'b10
    } shift_state_e;
endpackage

// >>> spi_tx_sync.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module spi_tx_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } sync_s;
    sync_s s;
    sync_s next_s;

    // The first stage feeds only the second stage.
    always_comb begin
        next_s.meta = d_in;
        next_s.stable = s.meta;
    end

    // Registers the synchroniser state.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_out = s.stable;
endmodule // spi_tx_sync
`default_nettype wire

// >>> spi_tx_fifo.sv
// Flip-flop FIFO with valid and ready on both sides and a flush input.
`timescale 1ns/1ps
`default_nettype none
module spi_tx_fifo #(
    parameter int W = 28,
    parameter int D = 32
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clr_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [W-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [W-1:0] rd_data_out,
    output logic [$clog2(D):0] count_out
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } fifo_s;
    fifo_s s;
    fifo_s next_s;
    logic push;
    logic pop;

    // Full and empty come straight from the count.
    assign wr_ready_out = (s.count != (AW+1)'(D));
    assign rd_valid_out = (s.count != '0);
    assign rd_data_out = s.mem[s.rp];
    assign count_out = s.count;
    assign push = wr_valid_in & wr_ready_out;
    assign pop = rd_valid_out & rd_ready_in;

    // Pointer and count update; a flush empties the queue.
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = wr_data_in;
            next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
        if (clr_in) begin
            next_s.wp = '0;
            next_s.rp = '0;
            next_s.count = '0;
        end
    end

    // Registers the FIFO state.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // spi_tx_fifo
`default_nettype wire

// >>> spi_link_partner.sv
// Serial link partner that clocks frames and captures the transmit line.
`timescale 1ns/1ps
`default_nettype none
module spi_link_partner (
    input wire logic clk_in,
    input wire logic busy_in,
    input wire logic simo_in,
    input wire logic [7:0] sel_in,
    output logic link_clk_out,
    output logic [15:0] rx_out,
    output logic [15:0] bits_out,
    output logic [7:0] sel_seen_out,
    output logic lost_out
);
    int starts;
    int used;
    // Quiet link clock and empty capture state at start.
    initial begin
        link_clk_out = 1'b0;
        rx_out = 16'h0000;
        bits_out = 16'h0000;
        sel_seen_out = 8'h00;
        lost_out = 1'b0;
        starts = 0;
        used = 0;
    end
    // Each start of a word is counted so a late burst call still pairs.
    always @(posedge busy_in) begin
        starts <= starts + 1;
    end
    // One frame: the clock runs only here, one spare rise after the bits.
    task automatic burst(input int len);
        int k;
        k = 0;
        while (starts <= used && k < 5000) begin
            @(posedge clk_in);
            k++;
        end
        if (k == 5000) lost_out = 1'b1;
        used++;
        #100;
        for (int i = 0; i <= len; i++) begin
            #80 link_clk_out = 1'b1;
            #80 link_clk_out = 1'b0;
            if (i == 0) sel_seen_out = sel_in;
            if (i < len) begin
                rx_out = {rx_out[14:0], simo_in};
                bits_out = bits_out + 16'h0001;
            end
        end
        // Realign to the system clock so later bus calls start on an edge.
        @(posedge clk_in);
    endtask
endmodule // spi_link_partner
`default_nettype wire

// >>> spi_tx_word_ctrl_tb.sv
// Register-level testbench of the transmit word and control path.
`timescale 1ns/1ps
`default_nettype none
module spi_tx_word_ctrl_tb;
    import spi_tx_pkg::*;
    logic clk, rst, psel, pen, pwr, acc_done, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, v;
    logic [3:0] pstrb;
    wire logic pready, pslverr, link_clk, simo, sel_oe, busy, lost;
    wire logic [31:0] prdata;
    wire logic [7:0] sel, sel_seen;
    wire logic [15:0] rx, bits;
    int err_total, comparisons, n;
    // Device under test with a short holding buffer.
    spi_tx_word_ctrl #(.DEPTH(4)) spi_tx_word_ctrl_i (
        .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PREADY_OUT(pready),
        .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
        .LINK_CLK_IN(link_clk), .SIMO_OUT(simo), .SEL_OUT(sel),
        .SEL_OE_OUT(sel_oe), .BUSY_OUT(busy));
    // Far side of the serial link.
    spi_link_partner spi_link_partner_i (
        .clk_in(clk), .busy_in(busy), .simo_in(simo), .sel_in(sel),
        .link_clk_out(link_clk), .rx_out(rx), .bits_out(bits),
        .sel_seen_out(sel_seen), .lost_out(lost));
    // System clock of 8 ns.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One APB transfer: setup, then access held until pready.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20000);
        if (k >= 20000) begin
            err_total++;
            close_out();
        end
        v = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // Waits a bounded time for the shifter to return to idle.
    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (busy !== 1'b0 && k < lim) begin
            @(posedge clk);
            k++;
        end
        chk(busy, 1'b0);
    endtask
    // Counts the cycles of idle select values between two words.
    task automatic gap(output int c);
        c = 0;
        while (sel !== 8'hFF && c < 400) begin
            @(posedge clk);
            c++;
        end
        c = 0;
        while (sel === 8'hFF && c < 500) begin
            @(posedge clk);
            c++;
        end
    endtask
    // Global guard against a hang.
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        close_out();
    end
    // Main sequence.
    initial begin
        {psel, pen, pwr, paddr, pwdata, pstrb, acc_done} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(sel, 8'hFF);
        chk({sel_oe, busy}, 2'b00);
        apb(1, OFS_GLOBAL, 32'h3, 4'hF);
        chk(sel_oe, 1'b1);
        // Control word carries select values and data together.
        apb(1, OFS_TX_CTRL, 32'h005A_1234, 4'hF);
        spi_link_partner_i.burst(16);
        chk(rx, 16'h1234);
        chk(sel_seen, 8'h5A);
        wait_idle(200);
        chk(sel, 8'hFF);
        // Every format select with its own character length.
        for (int i = 0; i < 4; i++) begin
            apb(1, OFS_FMT0 + 8'(4 * i), 32'(16 - 4 * i), 4'hF);
            apb(1, OFS_TX_CTRL, {6'h0, 2'(i), 24'h00F0A5}, 4'hF);
            spi_link_partner_i.burst(16 - 4 * i);
            chk(bits, 16'(16 * (i + 2) - 2 * i * (i + 1)));
            chk(rx & 16'(16'hFFFF >> (4 * i)), 16'hF0A5 >> 0 & 16'(16'hFFFF >> (4 * i)));
        end
        // Byte write to the control lane only, reserved bits set.
        apb(1, OFS_TX_CTRL, 32'hEA00_0000, 4'h8);
        repeat (30) @(posedge clk);
        chk(busy, 1'b0);
        apb(0, OFS_TX_CTRL, 32'h0, 4'h0);
        chk(v[31:24], 8'h02);
        apb(1, OFS_TX_WORD, 32'hFFFF_00C6, 4'hF);
        spi_link_partner_i.burst(8);
        chk(rx[7:0], 8'hC6);
        apb(0, OFS_TX_WORD, 32'h0, 4'h0);
        chk(v[31:16], 16'h0);
        wait_idle(200);
        // Select gap between queued words, without and with wait delay.
        apb(1, OFS_FMT0 + 8'h08, 32'h0000_0A08, 4'hF);
        for (int w = 0; w < 2; w++) begin
            apb(1, OFS_TX_CTRL, {5'h0, 1'(w), 26'h200_0011}, 4'hF);
            apb(1, OFS_TX_CTRL, {5'h0, 1'(w), 26'h200_0022}, 4'hF);
            // The gap opens before the frame's last fall, so watch it live.
            fork
                spi_link_partner_i.burst(8);
                gap(n);
            join
            chk(n >= 2 + 10 * w, 1'b1);
            chk(n < 12 + 500 * w, 1'b1);
            spi_link_partner_i.burst(8);
            chk(rx[7:0], 8'h22);
            wait_idle(300);
        end
        // Held select stays active, released after an unheld word.
        apb(1, OFS_TX_CTRL, 32'h120F_0055, 4'hF);
        spi_link_partner_i.burst(8);
        repeat (40) @(posedge clk);
        chk(sel, 8'h0F);
        apb(1, OFS_TX_CTRL, 32'h020F_0066, 4'hF);
        spi_link_partner_i.burst(8);
        wait_idle(200);
        chk(sel, 8'hFF);
        // Holding buffer fills until the bus write is held off.
        for (int j = 0; j < 5; j++) apb(1, OFS_TX_WORD, 32'(8'h10 + j), 4'hF);
        fork
            begin
                apb(1, OFS_TX_WORD, 32'h15, 4'hF);
                acc_done = 1'b1;
            end
            begin
                repeat (60) @(posedge clk);
                chk(acc_done, 1'b0);
                for (int j = 0; j < 6; j++) spi_link_partner_i.burst(8);
            end
        join
        chk(rx[7:0], 8'h15);
        wait_idle(200);
        // Clearing enable zeroes the payload and refuses new words.
        apb(1, OFS_TX_WORD, 32'h0000_7777, 4'hF);
        spi_link_partner_i.burst(8);
        chk(rx[7:0], 8'h77);
        apb(1, OFS_GLOBAL, 32'h0, 4'hF);
        apb(1, OFS_TX_WORD, 32'h0000_1111, 4'hF);
        apb(0, OFS_TX_WORD, 32'h0, 4'h0);
        chk(v[15:0], 16'h0);
        apb(0, OFS_TX_CTRL, 32'h0, 4'h0);
        chk(v[15:0], 16'h0);
        // Slave mode ignores the wait delay and releases the drivers.
        apb(1, OFS_GLOBAL, 32'h1, 4'hF);
        apb(1, OFS_FMT0, 32'h0000_C810, 4'hF);
        chk(sel_oe, 1'b0);
        apb(1, OFS_TX_CTRL, 32'h1400_00AB, 4'hF);
        spi_link_partner_i.burst(16);
        wait_idle(40);
        chk(rx, 16'h00AB);
        apb(0, OFS_STATUS, 32'h0, 4'h0);
        chk(v[3:0], 4'h0);
        apb(0, 8'hFC, 32'h0, 4'h0);
        chk(er, 1'b1);
        chk(lost, 1'b0);
        close_out();
    end
endmodule // spi_tx_word_ctrl_tb
`default_nettype wire
